// ### include/quad_dac_pkg.sv
// constants shared by the serial front end and the converter core
// assumes a single 10 MHz system clock sampling every pin
package quad_dac_pkg;
   // serial frame layout: read flag, channel/register address, data
   localparam int FRAME_BITS = 24;
   localparam int RW_BIT = 23;
   localparam int ADDR_HI = 19;
   localparam int ADDR_LO = 16;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
   localparam logic [CNT_W-1:0] CNT_OVER = 5'h19;
   // channels and group membership
   localparam int NUM_CH = 4;
   localparam int GROUP_A_CH = 2;
   localparam int GPIO_W = 2;
   // address map of the frame address field
   localparam logic [ADDR_W-1:0] ADDR_CH_BASE = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_GAIN_BASE = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_ZERO_BASE = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_GPIO = 4'hC;
   // reset values
   localparam logic [DATA_W-1:0] UNI_DEFAULT_CODE = 16'h0000;
   localparam logic [DATA_W-1:0] BIP_DEFAULT_CODE = 16'h0000;
   localparam logic [DATA_W-1:0] GAIN_TRIM_DEFAULT = 16'h0080;
   localparam logic [DATA_W-1:0] ZERO_TRIM_DEFAULT = 16'h0000;
   localparam logic [GPIO_W-1:0] GPIO_RELEASED = 2'h3;
   // flips two's complement into offset binary for the converter
   localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;
endpackage : quad_dac_pkg

// ### include/serial_frame_if.sv
// carries finished frames from the serial front end to the core
// and the reply word back for shifting out on the next frame
`timescale 1ns/1ps
interface serial_frame_if;
   import quad_dac_pkg::*;
   logic [FRAME_BITS-1:0] word;
   logic done;
   logic [FRAME_BITS-1:0] reply;
   logic load;
   modport front (output word, output done, input reply, input load);
   modport core (input word, input done, output reply, output load);
endinterface : serial_frame_if

// ### logic/serial_front.sv
// serial shift register with chip-select gating and serial output
// assumes cs_n, sclk and sdi are asynchronous pins, sclk far below clk
`timescale 1ns/1ps
module serial_front (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // frames to the core
   serial_frame_if.front link
);
   import quad_dac_pkg::*;

   logic [1:0] cs_sy;
   logic [1:0] sclk_sy;
   logic [1:0] sdi_sy;
   logic sclk_d;
   logic cs_d;
   logic fall;
   logic frame_end;
   logic active;
   logic [FRAME_BITS-1:0] shift_reg;
   logic [CNT_W-1:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////
   // two-stage synchronisers, only stage two is read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_sy <= 2'h3;
         sclk_sy <= 2'h0;
         sdi_sy <= 2'h0;
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         cs_sy <= {cs_sy[0], cs_n};
         sclk_sy <= {sclk_sy[0], sclk};
         sdi_sy <= {sdi_sy[0], sdi};
         sclk_d <= sclk_sy[1];
         cs_d <= cs_sy[1];
      end
   end

   assign fall = sclk_d & ~sclk_sy[1];
   assign active = ~cs_sy[1];
   assign frame_end = ~cs_d & cs_sy[1];

   ////////////////////////////////////////////////////////////////////
   // shift on falling sclk only while selected; reply reload wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= '0;
      end else if (link.load) begin
         shift_reg <= link.reply;
      end else if (active && fall) begin
         shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_sy[1]};
      end
   end

   // bit counter saturates so over-long frames are rejected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (!active) begin
         cnt_reg <= '0;
      end else if (fall && cnt_reg != CNT_OVER) begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // a frame counts only with exactly the full bit count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.done <= 1'b0;
         link.word <= '0;
      end else begin
         link.done <= frame_end && (cnt_reg == CNT_FULL);
         link.word <= shift_reg;
      end
   end

   // serial output released whenever chip select is high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sdo <= shift_reg[FRAME_BITS-1];
         sdo_oe <= active;
      end
   end
endmodule : serial_front

// ### logic/quad_dac_pins.sv
// pin-level control of a quad 16-bit converter: input registers,
// load latch, trim registers, pin reset, polarity and open-drain gpio
// assumes all pins are asynchronous to the 10 MHz clk
//
// Function
// - Serial bits are shifted in only while chip select is low.
// - The serial output is released while chip select is high.
// - A low load strobe makes the latch follow the input registers.
// - Converter levels update in the same cycle as the latch.
// - A low reset pin returns input registers and latches to default.
// - A low reset pin also restores gain and zero trim registers.
// - Each gpio is an input and an output that only pulls low.
// - Polarity select high makes channels 0 and 1 unipolar.
// - Codes are straight binary unipolar, two's complement bipolar.
`timescale 1ns/1ps
module quad_dac_pins (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial bus
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // control pins
   input wire logic latch_load_strobe_n,
   input wire logic reset_pin_n,
   input wire logic group_a_polarity_select,
   // open-drain general-purpose pins
   input wire logic [quad_dac_pkg::GPIO_W-1:0] gpio_in,
   output logic [quad_dac_pkg::GPIO_W-1:0] gpio_out,
   output logic [quad_dac_pkg::GPIO_W-1:0] gpio_oe,
   // converter side
   output logic [quad_dac_pkg::NUM_CH-1:0][quad_dac_pkg::DATA_W-1:0]
      dac_level,
   output logic group_a_unipolar
);
   import quad_dac_pkg::*;

   serial_frame_if link ();

   logic [1:0] strobe_sy;
   logic [1:0] rstpin_sy;
   logic [1:0] pol_sy;
   logic [GPIO_W-1:0] gpio_sy0;
   logic [GPIO_W-1:0] gpio_sy1;
   logic strobe_low;
   logic pin_reset;
   logic unipolar_a;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [NUM_CH-1:0][DATA_W-1:0] input_reg;
   logic [NUM_CH-1:0][DATA_W-1:0] latch_reg;
   logic [NUM_CH-1:0][DATA_W-1:0] gain_reg;
   logic [NUM_CH-1:0][DATA_W-1:0] zero_reg;
   logic [GPIO_W-1:0] gpio_release_reg;
   logic [DATA_W-1:0] rdata;

   ////////////////////////////////////////////////////////////////////
   // address decode helpers, used by the writes and the read mux

   // true when addr falls in the group of NUM_CH starting at base
   function automatic logic in_group(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] off;
      off = a - base;
      in_group = (a >= base) && (off < ADDR_W'(NUM_CH));
   endfunction : in_group

   // channel index inside a group
   function automatic logic [1:0] ch_of(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] off;
      off = a - base;
      ch_of = off[1:0];
   endfunction : ch_of

   // default code per channel depends on its polarity mode
   function automatic logic [DATA_W-1:0] default_code(input logic uni);
      default_code = uni ? UNI_DEFAULT_CODE : BIP_DEFAULT_CODE;
   endfunction : default_code

   ////////////////////////////////////////////////////////////////////
   // serial front end
   serial_front front (
      .clk(clk),
      .rst_n(rst_n),
      .cs_n(cs_n),
      .sclk(sclk),
      .sdi(sdi),
      .sdo(sdo),
      .sdo_oe(sdo_oe),
      .link(link)
   );

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers; second stage is the only one logic reads
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_sy <= 2'h3;
         rstpin_sy <= 2'h3;
         pol_sy <= 2'h3;
         gpio_sy0 <= GPIO_RELEASED;
         gpio_sy1 <= GPIO_RELEASED;
      end else begin
         strobe_sy <= {strobe_sy[0], latch_load_strobe_n};
         rstpin_sy <= {rstpin_sy[0], reset_pin_n};
         pol_sy <= {pol_sy[0], group_a_polarity_select};
         gpio_sy0 <= gpio_in;
         gpio_sy1 <= gpio_sy0;
      end
   end

   assign strobe_low = ~strobe_sy[1];
   assign pin_reset = ~rstpin_sy[1];
   assign unipolar_a = pol_sy[1];

   // frame fields
   assign wr = link.done && !link.word[RW_BIT];
   assign addr = link.word[ADDR_HI:ADDR_LO];
   assign wdata = link.word[DATA_W-1:0];

   ////////////////////////////////////////////////////////////////////
   // per-channel registers, latch and converter level
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         // group A follows the polarity pin, group B stays straight
         logic uni;
         logic [DATA_W-1:0] latch_next;
         assign uni = (c < GROUP_A_CH) ? unipolar_a : 1'b1;

         // input data register, restored by the reset pin
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               input_reg[c] <= UNI_DEFAULT_CODE;
            end else if (pin_reset) begin
               input_reg[c] <= default_code(uni);
            end else if (wr && in_group(addr, ADDR_CH_BASE) &&
                         ch_of(addr, ADDR_CH_BASE) == 2'(c)) begin
               input_reg[c] <= wdata;
            end
         end

         // transparent while the strobe is low, held when high
         always_comb begin
            if (pin_reset) begin
               latch_next = default_code(uni);
            end else if (strobe_low) begin
               latch_next = input_reg[c];
            end else begin
               latch_next = latch_reg[c];
            end
         end

         // latch and level load together so channels move as one
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               latch_reg[c] <= UNI_DEFAULT_CODE;
               dac_level[c] <= UNI_DEFAULT_CODE;
            end else begin
               latch_reg[c] <= latch_next;
               // bipolar codes become offset binary for the ladder
               dac_level[c] <= uni ? latch_next
                                   : (latch_next ^ SIGN_FLIP);
            end
         end

         // trim registers, only restored by reset, never cleared else
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               gain_reg[c] <= GAIN_TRIM_DEFAULT;
               zero_reg[c] <= ZERO_TRIM_DEFAULT;
            end else if (pin_reset) begin
               gain_reg[c] <= GAIN_TRIM_DEFAULT;
               zero_reg[c] <= ZERO_TRIM_DEFAULT;
            end else if (wr) begin
               if (in_group(addr, ADDR_GAIN_BASE) &&
                   ch_of(addr, ADDR_GAIN_BASE) == 2'(c)) begin
                  gain_reg[c] <= wdata;
               end
               if (in_group(addr, ADDR_ZERO_BASE) &&
                   ch_of(addr, ADDR_ZERO_BASE) == 2'(c)) begin
                  zero_reg[c] <= wdata;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // gpio: a zero bit pulls the pin low, a one releases it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gpio_release_reg <= GPIO_RELEASED;
      end else if (pin_reset) begin
         gpio_release_reg <= GPIO_RELEASED;
      end else if (wr && addr == ADDR_GPIO) begin
         gpio_release_reg <= wdata[GPIO_W-1:0];
      end
   end

   // never drive high; the board pull-up makes the high level
   assign gpio_out = '0;
   assign gpio_oe = ~gpio_release_reg;

   ////////////////////////////////////////////////////////////////////
   // read mux; gpio reads the pin itself, so a pulled-low pin reads 0
   // even if released, which lets software spot a shorted line
   always_comb begin
      rdata = '0;
      if (in_group(addr, ADDR_CH_BASE)) begin
         rdata = input_reg[ch_of(addr, ADDR_CH_BASE)];
      end else if (in_group(addr, ADDR_GAIN_BASE)) begin
         rdata = gain_reg[ch_of(addr, ADDR_GAIN_BASE)];
      end else if (in_group(addr, ADDR_ZERO_BASE)) begin
         rdata = zero_reg[ch_of(addr, ADDR_ZERO_BASE)];
      end else if (addr == ADDR_GPIO) begin
         rdata[GPIO_W-1:0] = gpio_sy1;
      end
   end

   // reply is shifted out during the following frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.reply <= '0;
         link.load <= 1'b0;
      end else begin
         link.load <= link.done && link.word[RW_BIT];
         link.reply <= {link.word[FRAME_BITS-1:DATA_W], rdata};
      end
   end

   // polarity state made visible to the analog side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         group_a_unipolar <= 1'b1;
      end else begin
         group_a_unipolar <= unipolar_a;
      end
   end
endmodule : quad_dac_pins

// ### tb/quad_dac_pins_props.sv
// assertions on the pins of the converter control block
// assumes clk samples every pin and rst_n is the only reset
`timescale 1ns/1ps
module quad_dac_pins_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial bus
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   // control pins
   input wire logic latch_load_strobe_n,
   input wire logic reset_pin_n,
   input wire logic group_a_polarity_select,
   // gpio
   input wire logic [quad_dac_pkg::GPIO_W-1:0] gpio_in,
   input wire logic [quad_dac_pkg::GPIO_W-1:0] gpio_out,
   input wire logic [quad_dac_pkg::GPIO_W-1:0] gpio_oe,
   // converter side
   input wire logic [quad_dac_pkg::NUM_CH-1:0][quad_dac_pkg::DATA_W-1:0]
      dac_level,
   input wire logic group_a_unipolar
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // two clocks of sync plus register before sdo follows chip select
   AST_SDO_RELEASED: assert property (cs_n [*4] |-> !sdo_oe)
      else $error("sdo driven while deselected");
   AST_SDO_DRIVEN: assert property (!cs_n [*4] |-> sdo_oe)
      else $error("sdo not driven while selected");
   AST_GPIO_NO_HIGH: assert property (gpio_out == 2'h0)
      else $error("gpio drives high");
   AST_GPIO_PIN_RESET: assert property (!reset_pin_n [*4]
      |-> gpio_oe == 2'h0)
      else $error("gpio not released by pin reset");
   AST_LATCH_HOLD: assert property ((latch_load_strobe_n
      && reset_pin_n && $stable(group_a_polarity_select)) [*5]
      |-> $stable(dac_level))
      else $error("levels moved with strobe high");
   AST_POLARITY: assert property ($stable(group_a_polarity_select)
      [*4] |-> group_a_unipolar == group_a_polarity_select)
      else $error("group a mode does not follow select");
   // bipolar default is zero code, which is mid scale at the ladder
   AST_PIN_RESET_LEVEL: assert property ((!reset_pin_n
      && $stable(group_a_unipolar)) [*5] |-> dac_level[2] == 16'h0000
      && dac_level[0] == (group_a_unipolar ? 16'h0000 : 16'h8000))
      else $error("pin reset level wrong");
   // mode flag and level are loaded on the same edge
   AST_MODE_FLIP: assert property ($changed(group_a_unipolar)
      && latch_load_strobe_n && reset_pin_n |-> $changed(dac_level[0][15]))
      else $error("mode change did not recode channel 0");
endmodule : quad_dac_pins_props

bind quad_dac_pins quad_dac_pins_props chk (.clk, .rst_n, .cs_n, .sclk,
   .sdi, .sdo, .sdo_oe, .latch_load_strobe_n, .reset_pin_n,
   .group_a_polarity_select, .gpio_in, .gpio_out, .gpio_oe, .dac_level,
   .group_a_unipolar);

// ### tb/host_serial_master.sv
// host model: serial bus master that writes and reads 24-bit frames
// assumes the caller is synchronous to clk
`timescale 1ns/1ps
module host_serial_master (
   // clock
   input wire logic clk,
   // serial pins
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // bit set on rising sclk, sdo taken just before the fall;
   // sclk rests low between frames, 800 ns per bit
   task automatic xfer(input logic [23:0] w, input int nbits,
      output logic [23:0] r);
      r = 24'h000000;
      @(posedge clk) cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 23; i > 23 - nbits; i--) begin
         sdi <= w[i];
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         // sdo moves four clocks after a fall, so look late in the phase
         r = {r[22:0], sdo};
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
      end
      cs_n <= 1'b1;
      sdi <= ~sdi; // line no longer meaningful once deselected
      repeat (10) @(posedge clk);
   endtask : xfer
   // clock edges with chip select high must be ignored
   task automatic stray(input int n);
      repeat (n) begin
         sdi <= 1'b1;
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : stray
endmodule : host_serial_master

// ### tb/quad_dac_pins_tb.sv
// self-checking bench of the converter pin logic
// assumes the host model drives the serial pins
`timescale 1ns/1ps
module quad_dac_pins_tb;
   import quad_dac_pkg::*;
   logic clk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe, strobe_n, rpin_n, pol;
   logic [GPIO_W-1:0] ext_lvl, gpio_out, gpio_oe;
   logic [NUM_CH-1:0][DATA_W-1:0] dac_level;
   logic uni;
   logic [15:0] d;
   int error_cnt = 0, samples_checked = 0, cycles = 0;
   // pull-up on each gpio, low when either side pulls
   wire logic [GPIO_W-1:0] gpio_pin = ext_lvl & ~gpio_oe;
   // no pull on sdo: a released line shows garbage, here the inverse
   wire logic sdo_line = sdo_oe ? sdo : ~sdo;
   quad_dac_pins uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .latch_load_strobe_n(strobe_n),
      .reset_pin_n(rpin_n), .group_a_polarity_select(pol),
      .gpio_in(gpio_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .dac_level(dac_level), .group_a_unipolar(uni));
   host_serial_master host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
      .sdi(sdi), .sdo(sdo_line));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic complete_run();
      if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // bound on the whole run, more than twice the expected length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      logic [23:0] r;
      host.xfer({4'h0, a, v}, 24, r);
   endtask : wr
   // reply comes back in the following frame, an unmapped read
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      logic [23:0] r;
      host.xfer({4'h8, a, 16'h0000}, 24, r);
      host.xfer(24'h8F0000, 24, r);
      v = r[15:0];
   endtask : rd
   ////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rd(ADDR_GAIN_BASE, d);
      check("gain0", GAIN_TRIM_DEFAULT, d);
      rd(ADDR_ZERO_BASE, d);
      check("zero0", ZERO_TRIM_DEFAULT, d);
      rd(ADDR_CH_BASE, d);
      check("ch0", UNI_DEFAULT_CODE, d);
   endtask : t_defaults
   task automatic t_latch();
      wr(4'h0, 16'h1234);
      wr(4'h2, 16'hABCD);
      check("held", 16'h0000, dac_level[0]);
      strobe_n <= 1'b0;
      repeat (6) @(posedge clk);
      check("uni0", 16'h1234, dac_level[0]);
      check("ch2", 16'hABCD, dac_level[2]);
      pol <= 1'b0;
      repeat (6) @(posedge clk);
      check("bip0", 16'h1234 ^ SIGN_FLIP, dac_level[0]);
      check("mode", 16'h0000, {15'h0, uni});
   endtask : t_latch
   task automatic t_select();
      logic [23:0] r;
      wr(4'h1, 16'h5555);
      host.stray(5);
      // a stray shift would show in the echo of the last frame
      host.xfer(24'h017777, 23, r);
      check("echo", 16'hAAAA, r[15:0]);
      repeat (6) @(posedge clk);
      check("bip1", 16'hD555, dac_level[1]);
      rd(4'h1, d);
      check("ch1", 16'h5555, d);
   endtask : t_select
   task automatic t_pin_reset();
      wr(4'h5, 16'h1111);
      rpin_n <= 1'b0;
      repeat (8) @(posedge clk);
      check("rst0", 16'h8000, dac_level[0]);
      check("rst2", 16'h0000, dac_level[2]);
      rpin_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(4'h5, d);
      check("gain1", GAIN_TRIM_DEFAULT, d);
      rd(4'h0, d);
      check("ch0r", BIP_DEFAULT_CODE, d);
   endtask : t_pin_reset
   task automatic t_gpio();
      wr(ADDR_GPIO, 16'h0002);
      check("oe", 16'h0001, {14'h0, gpio_oe});
      check("out", 16'h0000, {14'h0, gpio_out});
      rd(ADDR_GPIO, d);
      check("pins", 16'h0002, d);
      ext_lvl <= 2'h1;
      wr(ADDR_GPIO, 16'h0003);
      rd(ADDR_GPIO, d);
      check("ext", 16'h0001, d);
      // both pulled, then the reset pin must release them
      wr(ADDR_GPIO, 16'h0000);
      check("oe_all", 16'h0003, {14'h0, gpio_oe});
      rpin_n <= 1'b0;
      repeat (6) @(posedge clk);
      check("oe_rst", 16'h0000, {14'h0, gpio_oe});
      rpin_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : t_gpio
   task automatic t_mode_flip();
      // latch held, so only the recoding can move channel 0
      strobe_n <= 1'b1;
      repeat (4) @(posedge clk);
      check("bipr", 16'h8000, dac_level[0]);
      pol <= 1'b1;
      repeat (6) @(posedge clk);
      check("unir", 16'h0000, dac_level[0]);
      check("moder", 16'h0001, {15'h0, uni});
   endtask : t_mode_flip
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      strobe_n = 1'b1;
      rpin_n = 1'b1;
      pol = 1'b1;
      ext_lvl = 2'h3;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_defaults();
      t_latch();
      t_select();
      t_pin_reset();
      t_gpio();
      t_mode_flip();
      complete_run();
   end
endmodule : quad_dac_pins_tb
